//--- paf_override.sv
// per-pin alternate-function override for port b and port c
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "paf_map.svh"

module paf_override
	import paf_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// avalon-mm slave
	input  wire logic [2:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// clock source fuses and module enables
	input  wire logic        internal_rc_selected_i,
	input  wire logic        external_clock_selected_i,
	input  wire logic        async_timer_select_i,
	input  wire logic        reset_pin_disable_fuse_i,
	input  wire logic        serial_periph_enable_i,
	input  wire logic        serial_periph_master_sel_i,
	input  wire logic        two_wire_enable_i,
	// peripheral drive requests
	input  wire logic        spi_sck_out_i,
	input  wire logic        spi_slave_out_i,
	input  wire logic        spi_master_out_i,
	input  wire logic        timer2_compare_en_i,
	input  wire logic        timer2_compare_out_i,
	input  wire logic        timer1_compare_a_en_i,
	input  wire logic        timer1_compare_a_out_i,
	input  wire logic        timer1_compare_b_en_i,
	input  wire logic        timer1_compare_b_out_i,
	input  wire logic        twi_scl_pull_i,
	input  wire logic        twi_sda_pull_i,
	// peripheral inputs taken from the pads, and oscillator pin modes
	output logic             spi_sck_in_o,
	output logic             spi_master_in_o,
	output logic             spi_slave_in_o,
	output logic             spi_select_in_o,
	output logic             timer1_capture_in_o,
	output logic             reset_pin_level_o,
	output logic             twi_scl_in_o,
	output logic             twi_sda_in_o,
	output logic             timer_osc_mode_o,
	output logic             chip_osc_in_mode_o,
	output logic             chip_osc_out_mode_o,
	// port b pads
	input  wire logic [7:0]  pad_b_i,
	output logic      [7:0]  pad_b_o,
	output logic      [7:0]  pad_b_oe_n_o,
	output logic      [7:0]  pad_b_pullup_o,
	// port c pads
	input  wire logic [6:0]  pad_c_i,
	output logic      [6:0]  pad_c_o,
	output logic      [6:0]  pad_c_oe_n_o,
	output logic      [6:0]  pad_c_pullup_o
);

	// =====================================================
	// helper: merge port bits with one pin's overrides
	// =====================================================
	// returns {pullup, driver on, value}
	function automatic logic [2:0] paf_pin(
		input logic dir,
		input logic out,
		input logic pullup_global_off,
		input logic pullup_override_en,
		input logic pullup_override_val,
		input logic direction_override_en,
		input logic direction_override_val,
		input logic value_override_en,
		input logic value_override_val
	);
		logic pu;
		logic drv;
		logic val;
		pu  = pullup_override_en ? pullup_override_val : (~dir & out & ~pullup_global_off);
		drv = direction_override_en ? direction_override_val : dir;
		val = value_override_en ? value_override_val : out;
		return {pu, drv, val};
	endfunction

	// =====================================================
	// register state
	// =====================================================
	paf_bus_st_t st_r;          // bus answer state
	paf_bus_st_t st_nxt;
	logic [31:0] rdata_r;       // read data, held after answer
	logic [31:0] rdata_nxt;
	paf_byte_t   sf_r;          // special function bits
	paf_byte_t   sf_nxt;
	paf_byte_t   outb_r;        // port b output bits
	paf_byte_t   outb_nxt;
	paf_byte_t   dirb_r;        // port b direction bits
	paf_byte_t   dirb_nxt;
	logic [6:0]  outc_r;        // port c output bits
	logic [6:0]  outc_nxt;
	logic [6:0]  dirc_r;        // port c direction bits
	logic [6:0]  dirc_nxt;

	// =====================================================
	// pin mode decode
	// =====================================================
	logic spi_slave;            // spi on as slave
	logic spi_serial_periph_master_sel;             // spi on as master
	logic pullup_global_off;                  // global pull-up off
	logic pb7_clk;              // pb7 taken by an oscillator
	logic pb6_clk;              // pb6 taken by an oscillator
	logic pc6_rst;              // pc6 feeds reset circuitry
	paf_byte_t clk_b;           // port b pins that read as zero
	logic [6:0] clk_c;          // port c pins that read as zero

	// module enables decode straight into pin modes
	always_comb begin
		spi_slave = serial_periph_enable_i & ~serial_periph_master_sel_i;
		spi_serial_periph_master_sel  = serial_periph_enable_i & serial_periph_master_sel_i;
		pullup_global_off       = sf_r[`PAF_SF_PUD];
		// timer oscillator only with internal rc as chip clock
		timer_osc_mode_o = internal_rc_selected_i & async_timer_select_i;
		// crystal needs pb7; an external clock leaves it free
		chip_osc_out_mode_o = ~internal_rc_selected_i & ~external_clock_selected_i;
		chip_osc_in_mode_o  = ~internal_rc_selected_i;
		pb7_clk = chip_osc_out_mode_o | async_timer_select_i;
		pb6_clk = chip_osc_in_mode_o | timer_osc_mode_o;
		pc6_rst = ~reset_pin_disable_fuse_i;
		clk_b = 8'h00;
		clk_b[`PAF_PB_OSCO] = pb7_clk;
		clk_b[`PAF_PB_OSCI] = pb6_clk;
		clk_c = 7'h00;
		clk_c[`PAF_PC_RST] = pc6_rst;
	end

	// =====================================================
	// override signals per pin
	// =====================================================
	paf_byte_t  b_pullup_override_en, b_pullup_override_val, b_direction_override_en, b_direction_override_val, b_value_override_en, b_value_override_val, b_dien;
	logic [6:0] c_pullup_override_en, c_pullup_override_val, c_direction_override_en, c_direction_override_val, c_value_override_en, c_value_override_val, c_dien;
	logic two_wire_enable;                 // two-wire interface owns pc5/pc4

	// combinational so a mode change lands in the same cycle
	always_comb begin
		two_wire_enable   = two_wire_enable_i;
		b_pullup_override_en = 8'h00;
		b_pullup_override_val = 8'h00;
		b_direction_override_en = 8'h00;
		b_direction_override_val = 8'h00;
		b_value_override_en = 8'h00;
		b_value_override_val = 8'h00;
		b_dien = 8'hFF;
		// oscillator pins: no pull-up, no driver, no input
		b_pullup_override_en[`PAF_PB_OSCO] = pb7_clk;
		b_direction_override_en[`PAF_PB_OSCO] = pb7_clk;
		b_dien[`PAF_PB_OSCO] = ~pb7_clk;
		b_pullup_override_en[`PAF_PB_OSCI] = pb6_clk;
		b_direction_override_en[`PAF_PB_OSCI] = pb6_clk;
		b_dien[`PAF_PB_OSCI] = ~pb6_clk;
		// sck: input as slave, clock output as master
		b_pullup_override_en[`PAF_PB_SCK] = spi_slave;
		b_pullup_override_val[`PAF_PB_SCK] = outb_r[`PAF_PB_SCK] & ~pullup_global_off;
		b_direction_override_en[`PAF_PB_SCK] = spi_slave;
		b_value_override_en[`PAF_PB_SCK] = spi_serial_periph_master_sel;
		b_value_override_val[`PAF_PB_SCK] = spi_sck_out_i;
		// miso: input as master, slave data out as slave
		b_pullup_override_en[`PAF_PB_MISO] = spi_serial_periph_master_sel;
		b_pullup_override_val[`PAF_PB_MISO] = outb_r[`PAF_PB_MISO] & ~pullup_global_off;
		b_direction_override_en[`PAF_PB_MISO] = spi_serial_periph_master_sel;
		b_value_override_en[`PAF_PB_MISO] = spi_slave;
		b_value_override_val[`PAF_PB_MISO] = spi_slave_out_i;
		// mosi shares the pin with the timer2 compare output
		b_pullup_override_en[`PAF_PB_MOSI] = spi_slave;
		b_pullup_override_val[`PAF_PB_MOSI] = outb_r[`PAF_PB_MOSI] & ~pullup_global_off;
		b_direction_override_en[`PAF_PB_MOSI] = spi_slave;
		b_value_override_en[`PAF_PB_MOSI] = spi_serial_periph_master_sel | timer2_compare_en_i;
		b_value_override_val[`PAF_PB_MOSI] = (spi_serial_periph_master_sel & spi_master_out_i)
			| (timer2_compare_en_i & timer2_compare_out_i);
		// slave select: input as slave; as master, software or the timer1 compare b output drives its value
		b_pullup_override_en[`PAF_PB_SS] = spi_slave;
		b_pullup_override_val[`PAF_PB_SS] = outb_r[`PAF_PB_SS] & ~pullup_global_off;
		b_direction_override_en[`PAF_PB_SS] = spi_slave;
		b_value_override_en[`PAF_PB_SS] = timer1_compare_b_en_i;
		b_value_override_val[`PAF_PB_SS] = timer1_compare_b_out_i;
		// compare a output drives only if software made it an output
		b_value_override_en[`PAF_PB_OCA] = timer1_compare_a_en_i;
		b_value_override_val[`PAF_PB_OCA] = timer1_compare_a_out_i;
		c_pullup_override_en = 7'h00;
		c_pullup_override_val = 7'h00;
		c_direction_override_en = 7'h00;
		c_direction_override_val = 7'h00;
		c_value_override_en = 7'h00;
		c_value_override_val = 7'h00;
		c_dien = 7'h7F;
		// reset pin keeps its pull-up and drops the digital input
		c_pullup_override_en[`PAF_PC_RST] = pc6_rst;
		c_pullup_override_val[`PAF_PC_RST] = 1'b1;
		c_direction_override_en[`PAF_PC_RST] = pc6_rst;
		c_dien[`PAF_PC_RST] = ~pc6_rst;
		// two-wire lines: open drain, only ever pulled low
		c_pullup_override_en[`PAF_PC_SCL] = two_wire_enable;
		c_pullup_override_val[`PAF_PC_SCL] = outc_r[`PAF_PC_SCL] & ~pullup_global_off;
		c_direction_override_en[`PAF_PC_SCL] = two_wire_enable;
		c_direction_override_val[`PAF_PC_SCL] = twi_scl_pull_i;
		c_value_override_en[`PAF_PC_SCL] = two_wire_enable;
		c_pullup_override_en[`PAF_PC_SDA] = two_wire_enable;
		c_pullup_override_val[`PAF_PC_SDA] = outc_r[`PAF_PC_SDA] & ~pullup_global_off;
		c_direction_override_en[`PAF_PC_SDA] = two_wire_enable;
		c_direction_override_val[`PAF_PC_SDA] = twi_sda_pull_i;
		c_value_override_en[`PAF_PC_SDA] = two_wire_enable;
	end

	// =====================================================
	// pad drive
	// =====================================================
	logic [2:0] pin_res;        // scratch result of the merge

	// merge every pin; value is forced low when not driving
	always_comb begin
		pin_res = 3'b000;
		for (int i = 0; i < 8; i++) begin
			pin_res = paf_pin(dirb_r[i], outb_r[i], pullup_global_off, b_pullup_override_en[i], b_pullup_override_val[i],
				b_direction_override_en[i], b_direction_override_val[i], b_value_override_en[i], b_value_override_val[i]);
			pad_b_pullup_o[i] = pin_res[2];
			pad_b_oe_n_o[i]   = ~pin_res[1];
			pad_b_o[i]        = pin_res[1] & pin_res[0];
		end
		for (int i = 0; i < 7; i++) begin
			pin_res = paf_pin(dirc_r[i], outc_r[i], pullup_global_off, c_pullup_override_en[i], c_pullup_override_val[i],
				c_direction_override_en[i], c_direction_override_val[i], c_value_override_en[i], c_value_override_val[i]);
			pad_c_pullup_o[i] = pin_res[2];
			pad_c_oe_n_o[i]   = ~pin_res[1];
			pad_c_o[i]        = pin_res[1] & pin_res[0];
		end
	end

	// =====================================================
	// raw pad inputs to peripherals
	// =====================================================
	// peripherals synchronise these themselves
	always_comb begin
		spi_sck_in_o        = pad_b_i[`PAF_PB_SCK];
		spi_master_in_o     = pad_b_i[`PAF_PB_MISO];
		spi_slave_in_o      = pad_b_i[`PAF_PB_MOSI];
		spi_select_in_o     = pad_b_i[`PAF_PB_SS];
		timer1_capture_in_o = pad_b_i[`PAF_PB_CAP];
		reset_pin_level_o   = pad_c_i[`PAF_PC_RST];
	end

	// =====================================================
	// input synchronisers and two-wire spike filters
	// =====================================================
	paf_byte_t  sb1_r, sb2_r;   // port b: first stage, second stage
	logic [6:0] sc1_r, sc2_r;   // port c: first stage, second stage
	logic [1:0] filt_r;         // filtered {scl, sda}
	logic [1:0] filt_nxt;
	logic [3:0] fcnt_r [2];     // cycles each line has differed
	logic [3:0] fcnt_nxt [2];
	logic [1:0] line_s;         // synchronised {scl, sda}

	// a change is adopted only after it stood for the spike time
	always_comb begin
		line_s = {sc2_r[`PAF_PC_SCL], sc2_r[`PAF_PC_SDA]};
		filt_nxt = filt_r;
		for (int k = 0; k < 2; k++) begin
			fcnt_nxt[k] = 4'h0;
			if (line_s[k] != filt_r[k]) begin
				if (fcnt_r[k] >= 4'(`PAF_SPIKE_CYC - 1)) begin
					filt_nxt[k] = line_s[k];
				end else begin
					fcnt_nxt[k] = fcnt_r[k] + 4'h1;
				end
			end
		end
		twi_scl_in_o = filt_r[1];
		twi_sda_in_o = filt_r[0];
	end

	// synchronisers and filter state
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sb1_r     <= 8'h00;
			sb2_r     <= 8'h00;
			sc1_r     <= 7'h00;
			sc2_r     <= 7'h00;
			filt_r    <= 2'b11;
			fcnt_r[0] <= 4'h0;
			fcnt_r[1] <= 4'h0;
		end else begin
			sb1_r     <= pad_b_i;
			sb2_r     <= sb1_r;
			sc1_r     <= pad_c_i;
			sc2_r     <= sc1_r;
			filt_r    <= filt_nxt;
			fcnt_r[0] <= fcnt_nxt[0];
			fcnt_r[1] <= fcnt_nxt[1];
		end
	end

	// =====================================================
	// avalon slave: one wait state, then answer
	// =====================================================
	logic req;                  // read or write pending
	logic wr_go;                // write takes effect this edge
	logic [31:0] rd_view;       // value of the addressed register

	// clock pins and disabled inputs read back as zero
	always_comb begin
		req   = avs_read_i | avs_write_i;
		wr_go = avs_write_i & avs_byteenable_i[0] & (st_r == PAF_ACK);
		unique case (avs_address_i)
			`PAF_OFS_SPECIAL_FUNCTION_IO_CONTROL: rd_view = {24'h0, sf_r & `PAF_SF_MASK};
			`PAF_OFS_OUTB:  rd_view = {24'h0, outb_r & ~clk_b};
			`PAF_OFS_DIRB:  rd_view = {24'h0, dirb_r & ~clk_b};
			`PAF_OFS_PINB:  rd_view = {24'h0, sb2_r & b_dien & ~clk_b};
			`PAF_OFS_OUTC:  rd_view = {25'h0, outc_r & ~clk_c};
			`PAF_OFS_DIRC:  rd_view = {25'h0, dirc_r & ~clk_c};
			`PAF_OFS_PINC:  rd_view = {25'h0, sc2_r & c_dien & ~clk_c};
			`PAF_OFS_MODE:  rd_view = {25'h0, pc6_rst, two_wire_enable, spi_serial_periph_master_sel,
				spi_slave, timer_osc_mode_o, pb6_clk, pb7_clk};
		endcase
		avs_waitrequest_o = req & (st_r == PAF_IDLE);
		avs_readdata_o    = rdata_r;
	end

	// next values of the bus state and software registers
	always_comb begin
		st_nxt    = (req && st_r == PAF_IDLE) ? PAF_ACK : PAF_IDLE;
		rdata_nxt = (req && st_r == PAF_IDLE) ? rd_view : rdata_r;
		sf_nxt    = sf_r;
		outb_nxt  = outb_r;
		dirb_nxt  = dirb_r;
		outc_nxt  = outc_r;
		dirc_nxt  = dirc_r;
		if (wr_go) begin
			unique case (avs_address_i)
				`PAF_OFS_SPECIAL_FUNCTION_IO_CONTROL: sf_nxt = avs_writedata_i[7:0] & `PAF_SF_MASK;
				`PAF_OFS_OUTB:  outb_nxt = avs_writedata_i[7:0];
				`PAF_OFS_DIRB:  dirb_nxt = avs_writedata_i[7:0];
				`PAF_OFS_OUTC:  outc_nxt = avs_writedata_i[6:0];
				`PAF_OFS_DIRC:  dirc_nxt = avs_writedata_i[6:0];
				// input and mode views ignore writes
				default: sf_nxt = sf_r;
			endcase
		end
	end

	// bus and software register flops
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_r    <= PAF_IDLE;
			rdata_r <= 32'h0000_0000;
			sf_r    <= `PAF_SF_RST;
			outb_r  <= `PAF_PORT_RST;
			dirb_r  <= `PAF_PORT_RST;
			outc_r  <= 7'h00;
			dirc_r  <= 7'h00;
		end else begin
			st_r    <= st_nxt;
			rdata_r <= rdata_nxt;
			sf_r    <= sf_nxt;
			outb_r  <= outb_nxt;
			dirb_r  <= dirb_nxt;
			outc_r  <= outc_nxt;
			dirc_r  <= dirc_nxt;
		end
	end

	// =====================================================
	// assertions
	// =====================================================
	default clocking paf_cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	AST_PUD_OFF: assert property (pullup_global_off && !pc6_rst |-> pad_b_pullup_o == 8'h00
		&& pad_c_pullup_o == 7'h00)
		else $error("pull-up on while global pull-up off");
	AST_PB7_OSC: assert property (async_timer_select_i |-> pad_b_oe_n_o[7]
		&& !pad_b_pullup_o[7])
		else $error("pb7 not detached in async timer mode");
	AST_PB7_READ: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i == `PAF_OFS_DIRB && $past(pb7_clk) |-> !avs_readdata_o[7])
		else $error("pb7 direction read nonzero while clock pin");
	AST_PB6_OSC: assert property (!internal_rc_selected_i |-> pad_b_oe_n_o[6])
		else $error("pb6 driven while chip oscillator input");
	AST_SCK_IN: assert property (spi_slave |-> pad_b_oe_n_o[5]
		&& pad_b_pullup_o[5] == (outb_r[5] & ~pullup_global_off))
		else $error("sck not input as spi slave");
	AST_MISO_IN: assert property (spi_serial_periph_master_sel |-> pad_b_oe_n_o[4])
		else $error("miso not input as spi master");
	AST_MOSI_OR: assert property (spi_serial_periph_master_sel && dirb_r[3] && timer2_compare_en_i
		|-> pad_b_o[3] == (spi_master_out_i | timer2_compare_out_i))
		else $error("pb3 value not or of spi and timer2");
	AST_TWI_OD: assert property (two_wire_enable |-> !pad_c_o[5] && !pad_c_o[4]
		&& pad_c_oe_n_o[5] == !twi_scl_pull_i)
		else $error("two-wire line not open drain");
	AST_RST_PIN: assert property (pc6_rst |-> pad_c_oe_n_o[6] && pad_c_pullup_o[6])
		else $error("pc6 not released to reset circuitry");
	AST_WAIT_ONE: assert property (req && avs_waitrequest_o ##1 req
		|-> !avs_waitrequest_o)
		else $error("wait state longer than one cycle");

	COV_SPI_SLAVE: cover property (spi_slave ##1 spi_serial_periph_master_sel);
	COV_TWI_ON: cover property (!two_wire_enable ##1 two_wire_enable ##1 twi_scl_pull_i);
	COV_PUD_WR: cover property (wr_go && avs_address_i == `PAF_OFS_SPECIAL_FUNCTION_IO_CONTROL);
	COV_ASYNC: cover property (internal_rc_selected_i && async_timer_select_i);

endmodule

//--- paf_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PAF_MAP_SVH
`define PAF_MAP_SVH

// word offsets on the avalon slave (address is a word address)
`define PAF_OFS_SPECIAL_FUNCTION_IO_CONTROL  3'h0
`define PAF_OFS_OUTB   3'h1
`define PAF_OFS_DIRB   3'h2
`define PAF_OFS_PINB   3'h3
`define PAF_OFS_OUTC   3'h4
`define PAF_OFS_DIRC   3'h5
`define PAF_OFS_PINC   3'h6
`define PAF_OFS_MODE   3'h7

// special function register fields, and the port reset value
`define PAF_SF_PUD     2
`define PAF_SF_MASK    8'h0F
`define PAF_SF_RST     8'h00
`define PAF_PORT_RST   8'h00

// port b pins with alternate functions
`define PAF_PB_OSCO    7
`define PAF_PB_OSCI    6
`define PAF_PB_SCK     5
`define PAF_PB_MISO    4
`define PAF_PB_MOSI    3
`define PAF_PB_SS      2
`define PAF_PB_OCA     1
`define PAF_PB_CAP     0

// port c pins with alternate functions
`define PAF_PC_RST     6
`define PAF_PC_SCL     5
`define PAF_PC_SDA     4

// spike filter on the two-wire lines (least time, rounded up)
`define PAF_CLK_NS     50
`define PAF_SPIKE_NS   50
`define PAF_SPIKE_CYC  ((`PAF_SPIKE_NS + `PAF_CLK_NS - 1) / `PAF_CLK_NS)

`endif

//--- paf_pkg.sv
// types shared by the pin override block
package paf_pkg;
	// register bus answer state
	typedef enum logic {
		PAF_IDLE,
		PAF_ACK
	} paf_bus_st_t;
	// one port's worth of bits
	typedef logic [7:0] paf_byte_t;
endpackage

//--- paf_pad_model.sv
// pad and far-side model: resolves every pad level from all its drivers
`timescale 1ns/1ps

module paf_pad_model #(
	parameter int W = 8
) (
	// clock for the floating-line pattern
	input  wire logic         clk_i,
	// device side of the pads
	input  wire logic [W-1:0] dev_o_i,
	input  wire logic [W-1:0] dev_oe_n_i,
	input  wire logic [W-1:0] pullup_i,
	// external parties on the board
	input  wire logic [W-1:0] ext_en_i,
	input  wire logic [W-1:0] ext_val_i,
	// resolved level back to the device
	output logic      [W-1:0] pad_o
);
	// ============================================================
	// resolution
	// an undriven line toggles every cycle, so a stale level never passes
	logic [W-1:0] float_r = '0;

	always @(posedge clk_i) begin
		float_r <= ~float_r;
	end

	// device drive wins, then an external driver, then the pull-up
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!dev_oe_n_i[i]) pad_o[i] = dev_o_i[i];
			else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
			else if (pullup_i[i]) pad_o[i] = 1'b1;
			else pad_o[i] = float_r[i];
		end
	end
endmodule

//--- port_alt_function_override_tb.sv
// self-checking bench for the pin override block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, a); end end

module port_alt_function_override_tb;
	import paf_pkg::*;
	// ============================================================
	// stimulus and observed signals, named as the ports
	logic clk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0, wait_s;
	logic [2:0] avs_address_i = '0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_writedata_i = '0, avs_readdata_o, rdata_s;
	logic avs_waitrequest_o, internal_rc_selected_i = 1, external_clock_selected_i = 0;
	logic async_timer_select_i = 0, reset_pin_disable_fuse_i = 1, serial_periph_enable_i = 0;
	logic serial_periph_master_sel_i = 0, two_wire_enable_i = 0, spi_sck_out_i = 0;
	logic spi_slave_out_i = 0, spi_master_out_i = 0, timer2_compare_en_i = 0;
	logic timer2_compare_out_i = 0, timer1_compare_a_en_i = 0, timer1_compare_a_out_i = 0;
	logic timer1_compare_b_en_i = 0, timer1_compare_b_out_i = 0, twi_scl_pull_i = 0;
	logic twi_sda_pull_i = 0, spi_sck_in_o, spi_master_in_o, spi_slave_in_o, spi_select_in_o;
	logic timer1_capture_in_o, reset_pin_level_o, twi_scl_in_o, twi_sda_in_o;
	logic timer_osc_mode_o, chip_osc_in_mode_o, chip_osc_out_mode_o;
	logic [7:0] pad_b_i, pad_b_o, pad_b_oe_n_o, pad_b_pullup_o, ext_b_v = '0;
	logic [7:0] ext_b_en = 8'hFF;
	logic [6:0] pad_c_i, pad_c_o, pad_c_oe_n_o, pad_c_pullup_o, ext_c_v = '0;
	logic [6:0] ext_c_en = 7'h7F;
	int failures = 0, n_compared = 0;

	paf_override u_paf_override (.*);
	paf_pad_model #(.W(8)) u_pad_b (.clk_i(clk_i), .dev_o_i(pad_b_o), .dev_oe_n_i(pad_b_oe_n_o),
		.pullup_i(pad_b_pullup_o), .ext_en_i(ext_b_en), .ext_val_i(ext_b_v), .pad_o(pad_b_i));
	paf_pad_model #(.W(7)) u_pad_c (.clk_i(clk_i), .dev_o_i(pad_c_o), .dev_oe_n_i(pad_c_oe_n_o),
		.pullup_i(pad_c_pullup_o), .ext_en_i(ext_c_en), .ext_val_i(ext_c_v), .pad_o(pad_c_i));

	// ============================================================
	// clock and bus helpers
	always #25 clk_i = ~clk_i;
	// settled copies of the answer, taken before each sampling edge
	always @(negedge clk_i) begin
		wait_s = avs_waitrequest_o;
		rdata_s = avs_readdata_o;
	end

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// one avalon transfer held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0000_00, d};
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_s !== 1'b0 && n < 20);
		q = rdata_s[7:0];
		avs_write_i <= 0;
		avs_read_i <= 0;
		if (n >= 20) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask

	// read and compare the masked bits
	task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK("register read", e, q & m)
		@(negedge clk_i);
	endtask

	// ============================================================
	// scenarios
	task automatic t_pullup();
		rdc(3'h0, 8'hFF, 8'h00);
		wr(3'h0, 8'hFF);
		rdc(3'h0, 8'hFF, 8'h0F);
		wr(3'h0, 8'h00);
		wr(3'h1, 8'hFF);
		wr(3'h4, 8'h7F);
		@(negedge clk_i);
		`CHK("pullup b", 8'hFF, pad_b_pullup_o)
		`CHK("pullup c", 7'h7F, pad_c_pullup_o)
		wr(3'h0, 8'h04);
		@(negedge clk_i);
		`CHK("pullup b off", 8'h00, pad_b_pullup_o)
		wr(3'h0, 8'h00);
	endtask

	task automatic t_spi();
		wr(3'h2, 8'hFF);
		wr(3'h1, 8'hA5);
		@(negedge clk_i);
		`CHK("drive b", 8'hA5, pad_b_o & ~pad_b_oe_n_o)
		wr(3'h1, 8'hFF);
		// slave: sck, mosi and select forced to input with their pull-ups
		@(posedge clk_i);
		serial_periph_enable_i <= 1;
		ext_b_v <= 8'h28;
		@(negedge clk_i);
		`CHK("sck mosi in", 2'b11, {spi_sck_in_o, spi_slave_in_o})
		`CHK("slave oe_n", 8'h2C, pad_b_oe_n_o & 8'h3C)
		`CHK("slave pullup", 8'h2C, pad_b_pullup_o & 8'h3C)
		`CHK("select in", 1'b0, spi_select_in_o)
		@(posedge clk_i);
		serial_periph_master_sel_i <= 1;
		spi_master_out_i <= 1;
		ext_b_v <= 8'h10;
		@(negedge clk_i);
		`CHK("miso in", 1'b1, spi_master_in_o)
		`CHK("master oe_n", 8'h10, pad_b_oe_n_o & 8'h3C)
		`CHK("mosi", 1'b1, pad_b_o[3])
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			spi_master_out_i <= i[0];
			timer2_compare_en_i <= 1;
			timer2_compare_out_i <= i[1];
			@(negedge clk_i);
			`CHK("mosi or", i[0] | i[1], pad_b_o[3])
		end
	endtask

	task automatic t_timer();
		@(posedge clk_i);
		serial_periph_enable_i <= 0;
		timer1_compare_a_en_i <= 1;
		timer1_compare_b_en_i <= 1;
		timer1_compare_a_out_i <= 1;
		timer1_compare_b_out_i <= 1;
		timer2_compare_out_i <= 1;
		wr(3'h1, 8'h00);
		@(negedge clk_i);
		`CHK("compare outs", 3'b111, pad_b_o[3:1])
		wr(3'h2, 8'h00);
		ext_b_v <= 8'h01;
		@(negedge clk_i);
		`CHK("compare no dir", 3'b111, pad_b_oe_n_o[3:1])
		`CHK("capture", 1'b1, timer1_capture_in_o)
	endtask

	task automatic t_clock();
		wr(3'h1, 8'hFF);
		wr(3'h2, 8'hC0);
		@(posedge clk_i);
		async_timer_select_i <= 1;
		@(negedge clk_i);
		`CHK("osc pins oe_n", 2'b11, pad_b_oe_n_o[7:6])
		`CHK("osc pins pullup", 2'b00, pad_b_pullup_o[7:6])
		`CHK("timer osc", 1'b1, timer_osc_mode_o)
		rdc(3'h7, 8'h7F, 8'h07);
		rdc(3'h1, 8'hC0, 8'h00);
		rdc(3'h2, 8'hC0, 8'h00);
		rdc(3'h3, 8'hC0, 8'h00);
		@(posedge clk_i);
		async_timer_select_i <= 0;
		internal_rc_selected_i <= 0;
		external_clock_selected_i <= 1;
		@(negedge clk_i);
		`CHK("xtal in", 2'b01, pad_b_oe_n_o[7:6])
		`CHK("chip osc in", 1'b1, chip_osc_in_mode_o)
		`CHK("ext clock no out", 1'b0, chip_osc_out_mode_o)
		rdc(3'h2, 8'hC0, 8'h80);
		@(posedge clk_i);
		internal_rc_selected_i <= 1;
		external_clock_selected_i <= 0;
	endtask

	task automatic t_reset_twi();
		wr(3'h5, 8'h4F);
		wr(3'h4, 8'h7F);
		@(posedge clk_i);
		reset_pin_disable_fuse_i <= 0;
		two_wire_enable_i <= 1;
		twi_scl_pull_i <= 1;
		@(negedge clk_i);
		`CHK("reset pin oe_n", 1'b1, pad_c_oe_n_o[6])
		`CHK("reset level", 1'b0, reset_pin_level_o)
		`CHK("scl in", 1'b0, twi_scl_in_o)
		rdc(3'h7, 8'h60, 8'h60);
		`CHK("scl low", 2'b00, {pad_c_oe_n_o[5], pad_c_o[5]})
		`CHK("sda released", 2'b11, {pad_c_oe_n_o[4], pad_c_pullup_o[4]})
		rdc(3'h4, 8'h40, 8'h00);
		rdc(3'h5, 8'h40, 8'h00);
		rdc(3'h6, 8'h40, 8'h00);
		`CHK("sda idle", 1'b0, twi_sda_in_o)
		@(posedge clk_i);
		ext_c_v <= 7'h10;
		@(negedge clk_i);
		`CHK("sda filtered", 1'b0, twi_sda_in_o)
		repeat (4) @(negedge clk_i);
		`CHK("sda adopted", 1'b1, twi_sda_in_o)
		@(posedge clk_i);
		reset_pin_disable_fuse_i <= 1;
		@(negedge clk_i);
		`CHK("pc6 io", 1'b0, pad_c_oe_n_o[6])
		rdc(3'h5, 8'h40, 8'h40);
	endtask

	// ============================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		resetn_i <= 1;
		t_pullup();
		t_spi();
		t_timer();
		t_clock();
		t_reset_twi();
		stop_test();
	end
endmodule
